// >>> src/rofs_consts.vh
`ifndef ROFS_CONSTS_VH
`define ROFS_CONSTS_VH
`define ROFS_SEL_NONE 6'h00
`define ROFS_SEL_CURR 6'h03
`define ROFS_SEL_TORQ 6'h04
`define ROFS_SEL_FREQ 6'h05
`define ROFS_SEL_LEVEL 6'h06
`define ROFS_SEL_FAULT 6'h07
`define ROFS_SEL_WARN 6'h08
`define ROFS_SEL_OVC 6'h09
`define ROFS_SEL_OTEMP 6'h0a
`define ROFS_SEL_CLIM 6'h0b
`define ROFS_SEL_EXT 6'h0c
`define ROFS_SEL_BUS_LO 6'h1e
`define ROFS_SEL_BUS_HI 6'h25
`define ROFS_SEL_BUSSP 6'h26
`define ROFS_SCALE_MAX 400
`define ROFS_SCALE_RST 16'h0064
`define ROFS_HYST_PCT 90
`define ROFS_OVC_PCT 130
`define ROFS_OVC_TIME_S 30
`define ROFS_OTEMP_TIME_S 2
`define ROFS_LEVEL_STEP 16'h000a
`define ROFS_CLK_HZ 100000000
`define ROFS_TICK_HZ 1000
`endif

// >>> src/rofs_hyst_cmp.v
`timescale 1ns/1ps
`default_nettype none
// Threshold compare with release at 90 percent of the limit
module rofs_hyst_cmp #(
  parameter W = 16
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire en_i,
  input wire [W-1:0] value_i,
  input wire [W-1:0] limit_i,
  output reg hit_o
);
  wire [W+7:0] val_x100;
  wire [W+7:0] lim_x90;
  assign val_x100 = {8'h00, value_i} * 8'd100;
  assign lim_x90 = {8'h00, limit_i} * 8'd90;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hit_o <= 1'b0;
    end else if (!en_i) begin
      hit_o <= 1'b0;
    end else if (value_i >= limit_i) begin
      hit_o <= 1'b1;
    end else if (val_x100 < lim_x90) begin
      hit_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> src/rofs_relay.v
`timescale 1ns/1ps
`default_nettype none
`include "rofs_consts.vh"
// Summary of operation
// - Code 3: close when output current reaches scaled motor nominal current.
// - Code 4: close when torque current reaches scaled motor-data torque current.
// - Code 5: close when output frequency reaches scaled motor nominal frequency.
// - Code 6: close when ramp done and frequency equals setpoint; reopen on 1 Hz change.
// - Fault code: open on present or unacknowledged fault, close when operational.
// - Code 8: open while any general warning is active.
// - Code 9: open once 130 percent nominal current delivered for 30 s.
// - Code 10: open on motor overtemperature input; shutdown request 2 s later.
// - Code 11: open at current or torque limit setting, unscaled, 10 percent hysteresis.
// - Code 12: relay follows bit 0 of external relay control.
// - Codes 30-37: close while bus input bit 0-7 set, only with bus option.
// - Code 38: relay follows bus setpoint value.
// - Scaling is signed -400 to 400 percent, default 100.
// - Positive scaling keeps the limit function output; negative inverts it (codes 3, 4, 5, 11 only).
// - Limit codes 3-5 close at limit and release 10 percent below it.
module rofs_relay #(
  parameter TICK_DIV = `ROFS_CLK_HZ / `ROFS_TICK_HZ,
  parameter OVC_TICKS = `ROFS_OVC_TIME_S * `ROFS_TICK_HZ,
  parameter OTEMP_TICKS = `ROFS_OTEMP_TIME_S * `ROFS_TICK_HZ
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [5:0] relay_function_select_i,
  input wire [15:0] relay_limit_scale_i,
  input wire [15:0] external_relay_control_i,
  input wire [15:0] motor_nom_current_i,
  input wire [15:0] motor_torque_current_i,
  input wire [15:0] motor_nom_freq_i,
  input wire [15:0] inverter_nom_current_i,
  input wire [15:0] torque_current_limit_setting_i,
  input wire [15:0] current_limit_setting_i,
  input wire [15:0] out_current_i,
  input wire [15:0] torque_current_i,
  input wire [15:0] out_freq_i,
  input wire [15:0] setpoint_freq_i,
  input wire ramp_done_i,
  input wire fault_active_i,
  input wire fault_unacked_i,
  input wire warning_i,
  input wire motor_overtemp_pin_i,
  input wire bus_option_i,
  input wire [7:0] bus_in_bits_i,
  input wire bus_setpoint_bit_i,
  output reg relay_close_o,
  output reg otemp_shutdown_o,
  output reg ovc_warn_o
);
  wire signed [15:0] scale_s;
  wire scale_neg;
  wire [15:0] scale_mag;
  wire [8:0] scale_lim;
  reg [26:0] div_r;
  reg tick_r;
  reg [2:0] ot_sync_r;
  reg ot_lvl_r;
  reg [31:0] ovc_cnt_r;
  reg [31:0] ot_cnt_r;
  reg level_r;
  reg [15:0] level_sp_r;
  reg func_nxt;
  reg lim_func;
  wire hit_curr, hit_torq, hit_freq, hit_cl, hit_tl;
  wire [15:0] lim_curr, lim_torq, lim_freq;
  wire [5:0] sel;
  wire [31:0] ovc_thr_a, ovc_thr_b;

  // Scale limited to +-400 percent
  assign scale_s = relay_limit_scale_i;
  assign scale_neg = scale_s[15];
  assign scale_mag = scale_neg ? (16'h0000 - relay_limit_scale_i) : relay_limit_scale_i;
  assign scale_lim = (scale_mag > `ROFS_SCALE_MAX) ? 9'd400 : scale_mag[8:0];
  assign sel = relay_function_select_i;

  function [15:0] rofs_scale;
    input [15:0] base;
    input [8:0] pct;
    reg [24:0] prod;
    begin
      prod = ({9'h000, base} * {16'h0000, pct}) / 25'd100;
      rofs_scale = (prod > 25'h000_ffff) ? 16'hffff : prod[15:0];
    end
  endfunction

  assign lim_curr = rofs_scale(motor_nom_current_i, scale_lim);
  assign lim_torq = rofs_scale(motor_torque_current_i, scale_lim);
  assign lim_freq = rofs_scale(motor_nom_freq_i, scale_lim);

  rofs_hyst_cmp u_curr (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .en_i(1'b1),
    .value_i(out_current_i), .limit_i(lim_curr), .hit_o(hit_curr));
  rofs_hyst_cmp u_torq (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .en_i(1'b1),
    .value_i(torque_current_i), .limit_i(lim_torq), .hit_o(hit_torq));
  rofs_hyst_cmp u_freq (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .en_i(1'b1),
    .value_i(out_freq_i), .limit_i(lim_freq), .hit_o(hit_freq));
  // Unscaled limit settings for code 11
  rofs_hyst_cmp u_cl (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .en_i(1'b1),
    .value_i(out_current_i), .limit_i(current_limit_setting_i), .hit_o(hit_cl));
  rofs_hyst_cmp u_tl (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .en_i(1'b1),
    .value_i(torque_current_i), .limit_i(torque_current_limit_setting_i),
    .hit_o(hit_tl));

  // Millisecond tick
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= 27'h000_0000;
      tick_r <= 1'b0;
    end else if (div_r >= TICK_DIV - 1) begin
      div_r <= 27'h000_0000;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 27'h000_0001;
      tick_r <= 1'b0;
    end
  end

  // Overtemperature pin synchroniser
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ot_sync_r <= 3'h0;
      ot_lvl_r <= 1'b0;
    end else begin
      ot_sync_r <= {ot_sync_r[1:0], motor_overtemp_pin_i};
      if (ot_sync_r[1] == ot_sync_r[2]) begin
        ot_lvl_r <= ot_sync_r[2];
      end
    end
  end

  // Overcurrent integrator: up one per tick at or above 130 percent, down one otherwise
  assign ovc_thr_a = {16'h0000, out_current_i} * 32'd100;
  assign ovc_thr_b = {16'h0000, inverter_nom_current_i} * `ROFS_OVC_PCT;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovc_cnt_r <= 32'h0000_0000;
      ovc_warn_o <= 1'b0;
    end else begin
      if (tick_r) begin
        if (ovc_thr_a >= ovc_thr_b) begin
          if (ovc_cnt_r < OVC_TICKS) begin
            ovc_cnt_r <= ovc_cnt_r + 32'h0000_0001;
          end
        end else if (ovc_cnt_r != 32'h0000_0000) begin
          ovc_cnt_r <= ovc_cnt_r - 32'h0000_0001;
        end
      end
      ovc_warn_o <= (ovc_cnt_r >= OVC_TICKS);
    end
  end

  // Overtemperature shutdown delay
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ot_cnt_r <= 32'h0000_0000;
      otemp_shutdown_o <= 1'b0;
    end else if (!ot_lvl_r) begin
      ot_cnt_r <= 32'h0000_0000;
      otemp_shutdown_o <= 1'b0;
    end else begin
      if (tick_r && ot_cnt_r < OTEMP_TICKS) begin
        ot_cnt_r <= ot_cnt_r + 32'h0000_0001;
      end
      otemp_shutdown_o <= (ot_cnt_r >= OTEMP_TICKS);
    end
  end

  // Setpoint reached latch with 1 Hz release
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_r <= 1'b0;
      level_sp_r <= 16'h0000;
    end else if (!level_r) begin
      if (ramp_done_i && out_freq_i == setpoint_freq_i) begin
        level_r <= 1'b1;
        level_sp_r <= setpoint_freq_i;
      end
    // Extra top bit keeps the sum from wrapping near full scale
    end else if (({1'b0, setpoint_freq_i} >= {1'b0, level_sp_r} + {1'b0, `ROFS_LEVEL_STEP}) ||
                 ({1'b0, level_sp_r} >= {1'b0, setpoint_freq_i} + {1'b0, `ROFS_LEVEL_STEP})) begin
      level_r <= 1'b0;
    end
  end

  // Function select
  always @* begin
    func_nxt = 1'b0;
    lim_func = 1'b0;
    case (sel)
      `ROFS_SEL_CURR: begin
        func_nxt = hit_curr;
        lim_func = 1'b1;
      end
      `ROFS_SEL_TORQ: begin
        func_nxt = hit_torq;
        lim_func = 1'b1;
      end
      `ROFS_SEL_FREQ: begin
        func_nxt = hit_freq;
        lim_func = 1'b1;
      end
      `ROFS_SEL_LEVEL: func_nxt = level_r;
      `ROFS_SEL_FAULT: func_nxt = !(fault_active_i || fault_unacked_i);
      `ROFS_SEL_WARN: func_nxt = !warning_i;
      `ROFS_SEL_OVC: func_nxt = !ovc_warn_o;
      `ROFS_SEL_OTEMP: func_nxt = !ot_lvl_r;
      `ROFS_SEL_CLIM: begin
        func_nxt = !(hit_cl || hit_tl);
        lim_func = 1'b1;
      end
      `ROFS_SEL_EXT: func_nxt = external_relay_control_i[0];
      `ROFS_SEL_BUSSP: func_nxt = bus_setpoint_bit_i;
      default: begin
        if (sel >= `ROFS_SEL_BUS_LO && sel <= `ROFS_SEL_BUS_HI) begin
          func_nxt = bus_option_i & bus_in_bits_i[sel[2:0] - 3'd6];
        end else begin
          func_nxt = 1'b0;
        end
      end
    endcase
  end

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      relay_close_o <= 1'b0;
    end else begin
      relay_close_o <= func_nxt ^ (scale_neg & lim_func);
    end
  end
endmodule
`default_nettype wire

// >>> dv/rofs_relay_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rofs_relay_asserts (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [5:0] relay_function_select_i,
  input wire logic [15:0] relay_limit_scale_i,
  input wire logic [15:0] external_relay_control_i,
  input wire logic [15:0] motor_nom_current_i,
  input wire logic [15:0] current_limit_setting_i,
  input wire logic [15:0] out_current_i,
  input wire logic fault_active_i,
  input wire logic fault_unacked_i,
  input wire logic warning_i,
  input wire logic bus_option_i,
  input wire logic [7:0] bus_in_bits_i,
  input wire logic bus_setpoint_bit_i,
  input wire logic relay_close_o
);
  wire [5:0] fs = relay_function_select_i;
  wire [15:0] sc = relay_limit_scale_i;
  wire [15:0] cur = out_current_i;
  wire [15:0] nom = motor_nom_current_i;
  wire r = relay_close_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Current at or above the unit-scaled limit under the given scale
  sequence cur_hit(logic [15:0] s);
    fs == 6'h03 && sc == s && cur >= nom;
  endsequence
  sequence cur_low;
    fs == 6'h03 && sc == 16'h0064 && cur * 32'd10 < nom * 32'd9;
  endsequence
  a_idle_open: assert property ($past(fs) inside {0, [13:29]} |-> !r)
    else $error("relay closed on idle code");
  a_ext_follow: assert property ($past(fs) == 12 |-> r == $past(external_relay_control_i[0]))
    else $error("relay not following external bit");
  a_bus_bit: assert property ($past(fs) inside {[30:37]} |->
    r == ($past(bus_option_i) & $past(bus_in_bits_i[fs - 6'd30])))
    else $error("relay not following bus bit");
  a_bus_setpt: assert property ($past(fs) == 38 |-> r == $past(bus_setpoint_bit_i))
    else $error("relay not following bus setpoint");
  a_warn_open: assert property ($past(fs) == 8 |-> r == !$past(warning_i))
    else $error("relay wrong on warning");
  a_fault_open: assert property ($past(fs) == 7 |->
    r == !$past(fault_active_i | fault_unacked_i))
    else $error("relay wrong on fault");
  a_curr_close: assert property (cur_hit(16'h0064)[*4] |=> r)
    else $error("relay open at current limit");
  a_curr_release: assert property (cur_low[*4] |=> !r)
    else $error("relay held below release level");
  a_neg_invert: assert property (cur_hit(16'hff9c)[*4] |=> !r)
    else $error("relay not inverted by negative scale");
  a_clim_open: assert property ((fs == 11 && !sc[15] && cur >= current_limit_setting_i)[*4]
    |=> !r)
    else $error("relay closed at current limit setting");
endmodule
bind rofs_relay rofs_relay_asserts u_chk (.*);
`default_nettype wire

// >>> dv/rofs_contact_model.sv
`timescale 1ns/1ps
`default_nettype none
module rofs_contact_model #(
  parameter int DELAY = 2
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic coil_i,
  output logic contact_o
);
  logic [DELAY-1:0] arm_r;
  // Contact follows the coil after a mechanical settling delay
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) arm_r <= '0;
    else arm_r <= {arm_r[DELAY-2:0], coil_i};
  end
  assign contact_o = arm_r[DELAY-1];
endmodule
`default_nettype wire

// >>> dv/rofs_relay_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: value %b", $time, (a)); end end
module rofs_relay_bench;
  logic clk = 0, rst_n = 0, ramp = 0, flt = 0, unack = 0, wrn = 0, hot = 0, bopt = 0, bsp = 0;
  logic [5:0] sel = 0;
  logic [7:0] bits = 0;
  logic [15:0] scale = 16'h0064, ext = 0, cur = 0, tq = 0, frq = 0, spf = 0, clim = 16'h0078;
  logic [15:0] nomc = 16'h0064, inom = 16'h0064, tlim = 16'h0050;
  logic relay, shut, ovc, contact;
  int samples_checked = 0, bad_count = 0, i;
  initial forever #5 clk = ~clk;
  rofs_relay #(.TICK_DIV(4), .OVC_TICKS(8), .OTEMP_TICKS(4)) dut (
    .core_clk_i(clk), .nrst_i(rst_n), .relay_function_select_i(sel),
    .relay_limit_scale_i(scale), .external_relay_control_i(ext),
    .motor_nom_current_i(nomc), .motor_torque_current_i(16'h0032),
    .motor_nom_freq_i(16'h01f4), .inverter_nom_current_i(inom),
    .torque_current_limit_setting_i(tlim), .current_limit_setting_i(clim),
    .out_current_i(cur), .torque_current_i(tq), .out_freq_i(frq), .setpoint_freq_i(spf),
    .ramp_done_i(ramp), .fault_active_i(flt), .fault_unacked_i(unack), .warning_i(wrn),
    .motor_overtemp_pin_i(hot), .bus_option_i(bopt), .bus_in_bits_i(bits),
    .bus_setpoint_bit_i(bsp), .relay_close_o(relay), .otemp_shutdown_o(shut),
    .ovc_warn_o(ovc));
  rofs_contact_model u_contact (.core_clk_i(clk), .nrst_i(rst_n), .coil_i(relay),
    .contact_o(contact));
  task conclude;
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task t(input logic [5:0] s, input logic e);
    sel = s;
    repeat (8) @(negedge clk);
    `CHK(relay, e)
    `CHK(contact, e)
  endtask
  task wait_flag(input logic w);
    int n;
    for (n = 0; (w ? shut : ovc) !== 1'b1; n++) begin
      if (n == 200) begin
        bad_count++;
        conclude();
      end
      @(negedge clk);
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t(0, 0);
    t(13, 0);
    t(29, 0);
    ext = 16'h0001;
    t(12, 1);
    ext = 16'h0002;
    t(12, 0);
    wrn = 1;
    t(8, 0);
    wrn = 0;
    t(8, 1);
    flt = 1;
    t(7, 0);
    flt = 0;
    unack = 1;
    t(7, 0);
    unack = 0;
    t(7, 1);
    cur = 16'h0064;
    t(3, 1);
    cur = 16'h005f;
    t(3, 1);
    cur = 16'h0059;
    t(3, 0);
    cur = 16'h0063;
    t(3, 0);
    scale = 16'hff9c;
    cur = 16'h0064;
    t(3, 0);
    cur = 0;
    t(3, 1);
    scale = 16'h00c8;
    t(3, 0);
    cur = 16'h00c8;
    t(3, 1);
    cur = 0;
    t(3, 0);
    scale = 16'h01f4;
    cur = 16'h0190;
    t(3, 1);
    // Limit follows the nominal current input
    scale = 16'h0064;
    nomc = 16'h00c8;
    cur = 16'h00b3;
    t(3, 0);
    cur = 16'h00c8;
    t(3, 1);
    nomc = 16'h0064;
    tq = 16'h0032;
    t(4, 1);
    tq = 16'h0028;
    t(4, 0);
    frq = 16'h01f4;
    t(5, 1);
    frq = 16'h01c1;
    t(5, 0);
    scale = 16'h00c8;
    cur = 16'h0078;
    tq = 0;
    t(11, 0);
    cur = 0;
    tq = 16'h0050;
    t(11, 0);
    tq = 0;
    t(11, 1);
    tlim = 16'h0028;
    tq = 16'h0028;
    t(11, 0);
    tq = 0;
    t(11, 1);
    scale = 16'h0064;
    frq = 16'h012c;
    spf = 16'h012c;
    ramp = 1;
    t(6, 1);
    ramp = 0;
    spf = 16'h0135;
    t(6, 1);
    spf = 16'h0136;
    t(6, 0);
    bopt = 1;
    bits = 8'h5a;
    for (i = 0; i < 8; i++) t(6'd30 + i[5:0], bits[i]);
    bopt = 0;
    bits = 8'hff;
    t(33, 0);
    bsp = 1;
    t(38, 1);
    bsp = 0;
    t(38, 0);
    // Overcurrent threshold follows the inverter nominal current
    inom = 16'h00c8;
    cur = 16'h00c8;
    repeat (40) @(negedge clk);
    `CHK(ovc, 1'b0)
    cur = 16'h0104;
    t(9, 1);
    wait_flag(0);
    t(9, 0);
    cur = 0;
    hot = 1;
    t(10, 0);
    `CHK(shut, 1'b0)
    wait_flag(1);
    hot = 0;
    t(10, 1);
    `CHK(shut, 1'b0)
    conclude();
  end
endmodule
`default_nettype wire
